// ### cods_cfg.svh
// Constants for the opcode decode subset: opcodes, flag positions, lengths and reset values.
`ifndef CODS_CFG_SVH
`define CODS_CFG_SVH

// Status register bit positions.
`define CODS_STAT_NEG   7
`define CODS_STAT_OVF   6
`define CODS_STAT_ONE   5
`define CODS_STAT_BRK   4
`define CODS_STAT_DEC   3
`define CODS_STAT_IRQD  2
`define CODS_STAT_ZERO  1
`define CODS_STAT_CARRY 0

// Reset values of the architectural state.
`define CODS_STAT_RESET 8'h34
`define CODS_ACC_RESET  8'h00
`define CODS_PC_RESET   16'h0000

// Add-with-carry opcodes, one per addressing mode.
`define CODS_OP_ADC_ABS  8'h6D
`define CODS_OP_ADC_ABSX 8'h7D
`define CODS_OP_ADC_ABSY 8'h79
`define CODS_OP_ADC_IMM  8'h69
`define CODS_OP_ADC_ZP   8'h65
`define CODS_OP_ADC_ZPXI 8'h61
`define CODS_OP_ADC_ZPX  8'h75
`define CODS_OP_ADC_ZPI  8'h72
`define CODS_OP_ADC_ZPIY 8'h71

// Bitwise conjunction opcodes, one per addressing mode.
`define CODS_OP_AND_ABS  8'h2D
`define CODS_OP_AND_ABSX 8'h3D
`define CODS_OP_AND_ABSY 8'h39
`define CODS_OP_AND_IMM  8'h29
`define CODS_OP_AND_ZP   8'h25
`define CODS_OP_AND_ZPXI 8'h21
`define CODS_OP_AND_ZPX  8'h35
`define CODS_OP_AND_ZPI  8'h32
`define CODS_OP_AND_ZPIY 8'h31

// Branch-on-bit-clear opcodes share a low nibble; the high nibble is the bit number.
`define CODS_OP_BBR_LOW  4'hF

// Instruction lengths in bytes.
`define CODS_LEN_ONE   2'h1
`define CODS_LEN_TWO   2'h2
`define CODS_LEN_THREE 2'h3

`endif

// ### cods_pkg.sv
// Types shared by the opcode decode subset.
`default_nettype none
package cods_pkg;

  typedef enum logic [1:0] {
    CODS_CL_NONE = 2'b00,
    CODS_CL_ADC  = 2'b01,
    CODS_CL_AND  = 2'b10,
    CODS_CL_BBR  = 2'b11
  } cods_class_e;

  // One fetched instruction: opcode, memory operand and branch displacement.
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] operand;
    logic [7:0] relOffset;
  } cods_insn_s;

  // Decoded form of an opcode.
  typedef struct packed {
    cods_class_e cls;
    logic [2:0]  bitSel;
    logic [1:0]  length;
  } cods_dec_s;

endpackage
`default_nettype wire

// ### cods_decoder.sv
// Opcode classifier: maps an opcode byte to its operation class, test bit and length.
`timescale 1ns/1ps
`default_nettype none
`include "cods_cfg.svh"

module cods_decoder (
  input  wire logic [7:0]         opcode,
  output var cods_pkg::cods_dec_s dec
);

  // Pure lookup; unknown opcodes fall out as class none with length one.
  always_comb begin
    dec.cls    = cods_pkg::CODS_CL_NONE;
    dec.bitSel = 3'h0;
    dec.length = `CODS_LEN_ONE;
    case (opcode)
      `CODS_OP_ADC_ABS, `CODS_OP_ADC_ABSX, `CODS_OP_ADC_ABSY: begin
        dec.cls    = cods_pkg::CODS_CL_ADC;
        dec.length = `CODS_LEN_THREE;
      end
      `CODS_OP_ADC_IMM, `CODS_OP_ADC_ZP, `CODS_OP_ADC_ZPXI, `CODS_OP_ADC_ZPX,
      `CODS_OP_ADC_ZPI, `CODS_OP_ADC_ZPIY: begin
        dec.cls    = cods_pkg::CODS_CL_ADC;
        dec.length = `CODS_LEN_TWO;
      end
      `CODS_OP_AND_ABS, `CODS_OP_AND_ABSX, `CODS_OP_AND_ABSY: begin
        dec.cls    = cods_pkg::CODS_CL_AND;
        dec.length = `CODS_LEN_THREE;
      end
      `CODS_OP_AND_IMM, `CODS_OP_AND_ZP, `CODS_OP_AND_ZPXI, `CODS_OP_AND_ZPX,
      `CODS_OP_AND_ZPI, `CODS_OP_AND_ZPIY: begin
        dec.cls    = cods_pkg::CODS_CL_AND;
        dec.length = `CODS_LEN_TWO;
      end
      default: begin
        // Bit number sits in the high nibble; with bit 7 of the opcode set the opcode is not decoded and stays class none.
        if (opcode[3:0] == `CODS_OP_BBR_LOW && !opcode[7]) begin
          dec.cls    = cods_pkg::CODS_CL_BBR;
          dec.bitSel = opcode[6:4];
          dec.length = `CODS_LEN_THREE;
        end
      end
    endcase
  end

endmodule
`default_nettype wire

// ### cods_core.sv
// Execution core for the add-with-carry, conjunction and branch-on-bit-clear opcodes.
// Function
// - Opcodes 6D, 7D, 79, 69, 65, 61, 75, 72 and 71 add memory and carry into the accumulator and set N, V, Z and C.
// - Opcodes 2D, 3D, 39, 29, 25, 21, 35, 32 and 31 AND memory into the accumulator and set only N and Z.
// - Opcodes 0F to 3F test bits 0 to 3 of a zero-page byte and branch when the bit is clear, flags untouched.
// - Opcodes 4F to 7F test bits 4 to 7 of a zero-page byte and branch when the bit is clear, flags untouched.
// - All state holds for any length of time while the clock is stopped or the enable is low.
`timescale 1ns/1ps
`default_nettype none
`include "cods_cfg.svh"

module cods_core (
  input  wire logic                 mclk,
  input  wire logic                 reset,
  input  wire logic                 clkEn,
  input  wire logic                 insnValid,
  input  wire cods_pkg::cods_insn_s insnIn,
  output logic [7:0]                acc,
  output logic [7:0]                status,
  output logic [15:0]               pc,
  output logic                      done,
  output logic                      branchTaken,
  output logic                      illegal
);

  cods_pkg::cods_dec_s dec;
  logic                accept;
  logic [8:0]          sum;
  logic                testBit;
  logic [15:0]         seqPc;
  logic [15:0]         relExt;
  logic [7:0]          next_acc;
  logic [7:0]          next_status;
  logic [15:0]         next_pc;
  logic                next_done;
  logic                next_branchTaken;
  logic                next_illegal;

  cods_decoder u_decoder (
    .opcode (insnIn.opcode),
    .dec    (dec)
  );

  // Work is only taken while enabled, so a stopped enable behaves like a stopped clock.
  assign accept  = insnValid && clkEn;
  // Nine-bit sum keeps the carry out; binary arithmetic only.
  assign sum     = {1'b0, acc} + {1'b0, insnIn.operand} + {8'h00, status[`CODS_STAT_CARRY]};
  // The bit under test is picked by the decoded bit number, so no mask table is needed.
  assign testBit = insnIn.operand[dec.bitSel];
  assign seqPc   = pc + {14'h0000, dec.length};
  assign relExt  = {{8{insnIn.relOffset[7]}}, insnIn.relOffset};

  // Next-state computation for the architectural registers and the result strobes.
  always_comb begin
    next_acc         = acc;
    next_status      = status;
    next_pc          = pc;
    next_done        = 1'b0;
    next_branchTaken = 1'b0;
    next_illegal     = 1'b0;
    if (accept) begin
      next_done = 1'b1;
      // Every accepted word moves past its own bytes, whatever its class turns out to be.
      next_pc   = seqPc;
      case (dec.cls)
        cods_pkg::CODS_CL_ADC: begin
          next_acc                     = sum[7:0];
          next_status[`CODS_STAT_NEG]  = sum[7];
          next_status[`CODS_STAT_ZERO] = (sum[7:0] == 8'h00);
          next_status[`CODS_STAT_CARRY] = sum[8];
          // Overflow: operands share a sign that the result does not.
          next_status[`CODS_STAT_OVF]  = (acc[7] == insnIn.operand[7]) && (sum[7] != acc[7]);
        end
        cods_pkg::CODS_CL_AND: begin
          next_acc                     = acc & insnIn.operand;
          next_status[`CODS_STAT_NEG]  = acc[7] & insnIn.operand[7];
          next_status[`CODS_STAT_ZERO] = ((acc & insnIn.operand) == 8'h00);
        end
        cods_pkg::CODS_CL_BBR: begin
          // Flags are deliberately left alone; only the program counter moves.
          if (!testBit) begin
            next_pc          = seqPc + relExt;
            next_branchTaken = 1'b1;
          end
        end
        default: begin
          // Opcodes outside this subset are reported and skipped one byte.
          next_illegal = 1'b1;
        end
      endcase
    end else if (!clkEn) begin
      // Frozen: strobes hold too, so nothing changes while the enable is low.
      next_done        = done;
      next_branchTaken = branchTaken;
      next_illegal     = illegal;
    end
    // The constant bit is forced on every path so no write can clear it.
    next_status[`CODS_STAT_ONE] = 1'b1;
  end

  // Plain registers with no refresh or timeout, so the clock may stop indefinitely.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      acc         <= `CODS_ACC_RESET;
      status      <= `CODS_STAT_RESET;
      pc          <= `CODS_PC_RESET;
      done        <= 1'b0;
      branchTaken <= 1'b0;
      illegal     <= 1'b0;
    end else begin
      acc         <= next_acc;
      status      <= next_status;
      pc          <= next_pc;
      done        <= next_done;
      branchTaken <= next_branchTaken;
      illegal     <= next_illegal;
    end
  end

  // Checks on the observable effect of each operation class.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // Each class is caught at the edge that accepts it; the consequents look one edge later.

  sequence s_adcTaken;
    accept && dec.cls == cods_pkg::CODS_CL_ADC;
  endsequence

  sequence s_andTaken;
    accept && dec.cls == cods_pkg::CODS_CL_AND;
  endsequence

  // Branch checks are split by bit half so each group of test bits has its own label.
  sequence s_bbrLow;
    accept && dec.cls == cods_pkg::CODS_CL_BBR && !dec.bitSel[2];
  endsequence

  sequence s_bbrHigh;
    accept && dec.cls == cods_pkg::CODS_CL_BBR && dec.bitSel[2];
  endsequence

  chk_adc_sum_carry: assert property (
    s_adcTaken |=> {status[0], acc} == ({1'b0, $past(acc)} + {1'b0, $past(insnIn.operand)}
                    + {8'h00, $past(status[0])}) && status[7] == acc[7]
                    && status[1] == (acc == 8'h00) && pc == $past(pc) + {14'h0000, $past(dec.length)})
    else $error("add with carry gave a wrong sum or flag");

  chk_adc_overflow: assert property (
    s_adcTaken |=> status[6] == (($past(acc[7]) == $past(insnIn.operand[7]))
                                 && (acc[7] != $past(acc[7]))))
    else $error("add with carry gave a wrong overflow flag");

  chk_and_flags_kept: assert property (
    s_andTaken |=> acc == ($past(acc) & $past(insnIn.operand)) && status[7] == acc[7]
                   && status[1] == (acc == 8'h00) && status[6] == $past(status[6])
                   && status[0] == $past(status[0]) && done)
    else $error("conjunction gave a wrong result or touched V or C");

  chk_bbr_low_branch: assert property (
    s_bbrLow |=> status == $past(status) && acc == $past(acc)
                 && branchTaken == !$past(testBit)
                 && pc == ($past(testBit) ? $past(seqPc) : $past(seqPc) + $past(relExt)))
    else $error("low bit test branched wrongly or changed flags");

  chk_bbr_high_branch: assert property (
    s_bbrHigh |=> status == $past(status) && acc == $past(acc) && branchTaken == !$past(testBit)
                  && pc == ($past(testBit) ? $past(seqPc) : $past(seqPc) + $past(relExt)))
    else $error("high bit test branched wrongly or changed flags");

  chk_static_hold: assert property (
    !clkEn [*2] |-> $stable(acc) && $stable(status) && $stable(pc) && $stable(done)
                    && $stable(branchTaken) && $stable(illegal))
    else $error("state moved while the enable was low");

  chk_status_one: assert property (
    ##1 status[`CODS_STAT_ONE] && $past(status[`CODS_STAT_ONE]))
    else $error("constant status bit is not one");

  chk_illegal_skip: assert property (
    accept && dec.cls == cods_pkg::CODS_CL_NONE |=> illegal && !branchTaken
                                                   && pc == $past(pc) + 16'h0001
                                                   && acc == $past(acc))
    else $error("unknown opcode was not skipped cleanly");

  // Strobe checks: one done pulse per accepted word, nothing on an idle enabled edge.
  sequence s_anyTaken;
    accept;
  endsequence

  sequence s_idleEdge;
    clkEn && !insnValid;
  endsequence

  // A lost pulse would let a downstream counter drop instructions without any other symptom.
  chk_done_pulse: assert property (
    s_anyTaken |=> done)
    else $error("accepted instruction gave no done pulse");

  // An idle edge clears the strobes and leaves every register as it was.
  chk_idle_quiet: assert property (
    s_idleEdge |=> !done && !branchTaken && !illegal && $stable(acc) && $stable(status)
                   && $stable(pc))
    else $error("idle edge moved state or left a strobe high");

  // The qualifying strobes never stand without done, and never both at once.
  chk_strobe_pairing: assert property (
    (branchTaken || illegal) |-> done && !(branchTaken && illegal))
    else $error("branch or illegal strobe stood without done");

  // Break, decimal and interrupt-disable belong to other instructions and never move here.
  chk_mode_bits_kept: assert property (
    s_anyTaken |=> status[`CODS_STAT_BRK:`CODS_STAT_IRQD]
                   == $past(status[`CODS_STAT_BRK:`CODS_STAT_IRQD]))
    else $error("break, decimal or interrupt-disable bit moved");

  // Reset is checked while it stands, so the default disable is overridden here.
  // The check lands one edge late because the first reset may arrive before any clock edge.
  chk_reset_values: assert property (
    disable iff (1'b0) reset |=> acc == `CODS_ACC_RESET && status == `CODS_STAT_RESET
                                 && pc == `CODS_PC_RESET && !done && !branchTaken && !illegal)
    else $error("registers held wrong values under reset");

endmodule
`default_nettype wire

// ### cods_prog_mem.sv
// Program memory model that feeds instruction words to the core with random stalls.
`timescale 1ns/1ps
`default_nettype none

module cods_prog_mem (
  input  wire logic                mclk,
  input  wire logic                reset,
  input  wire logic                clkEn,
  output logic                     insnValid,
  output var cods_pkg::cods_insn_s insnIn
);
  cods_pkg::cods_insn_s q[$];
  logic [31:0]          rng = 32'h1D2B;

  // The bus starts idle.
  initial begin
    insnValid <= 1'b0;
    insnIn    <= '0;
  end

  // The bench loads words here; they leave in the order loaded.
  task automatic push(input cods_pkg::cods_insn_s w);
    q.push_back(w);
  endtask

  // A word the core has not taken stays put outside reset. An idle bus shows the inverse of its previous value,
  // so stale data changes every cycle and never passes for a held value.
  always @(posedge mclk) begin
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    if (!(insnValid && !clkEn && !reset)) begin
      if (!reset && q.size() != 0 && rng[2:0] != 3'h0) begin
        insnValid <= 1'b1;
        insnIn    <= q.pop_front();
      end else begin
        insnValid <= 1'b0;
        insnIn    <= ~insnIn;
      end
    end
  end
endmodule

`default_nettype wire

// ### cpu_opcode_decode_subset_tb_top.sv
// Self-checking bench for the opcode decode subset core.
`timescale 1ns/1ps
`default_nettype none
`include "cods_cfg.svh"

module cpu_opcode_decode_subset_tb_top;
  logic                 mclk;
  logic                 reset = 1'b1;
  logic                 clkEn = 1'b1;
  logic                 insnValid;
  cods_pkg::cods_insn_s insnIn;
  logic [7:0]           acc;
  logic [7:0]           status;
  logic [15:0]          pc;
  logic                 done;
  logic                 branchTaken;
  logic                 illegal;
  logic [7:0]           expAcc = `CODS_ACC_RESET;
  logic [7:0]           expStat = `CODS_STAT_RESET;
  logic [15:0]          expPc = `CODS_PC_RESET;
  logic                 expDone = 1'b0;
  logic                 expBr = 1'b0;
  logic                 expIll = 1'b0;
  int                   num_errors = 0;
  int                   num_checks = 0;
  int                   cycles = 0;
  logic [31:0]          seed = 32'h3B55;
  localparam logic [7:0] OPS [26] = '{8'h6D, 8'h7D, 8'h79, 8'h69, 8'h65, 8'h61, 8'h75, 8'h72,
    8'h71, 8'h2D, 8'h3D, 8'h39, 8'h29, 8'h25, 8'h21, 8'h35, 8'h32, 8'h31, 8'h0F, 8'h1F,
    8'h2F, 8'h3F, 8'h4F, 8'h5F, 8'h6F, 8'h7F};

  cods_core cods_core_inst (.mclk(mclk), .reset(reset), .clkEn(clkEn), .insnValid(insnValid),
    .insnIn(insnIn), .acc(acc), .status(status), .pc(pc), .done(done),
    .branchTaken(branchTaken), .illegal(illegal));

  cods_prog_mem cods_prog_mem_inst (.mclk(mclk), .reset(reset), .clkEn(clkEn),
    .insnValid(insnValid), .insnIn(insnIn));

  // Free-running 100 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  // Returns the next accumulator, status, pc, branch-taken and illegal flags.
  function automatic logic [33:0] predict(input logic [7:0] a, input logic [7:0] s,
      input logic [15:0] p, input cods_pkg::cods_insn_s w);
    logic [8:0] sum;
    logic       br;
    logic       ill;
    sum = {1'b0, a} + {1'b0, w.operand} + {8'h00, s[0]};
    br = 1'b0;
    ill = 1'b0;
    if (w.opcode inside {8'h6D, 8'h7D, 8'h79, 8'h69, 8'h65, 8'h61,
                         8'h75, 8'h72, 8'h71}) begin
      s[6] = ~(a[7] ^ w.operand[7]) & (a[7] ^ sum[7]);
      s[0] = sum[8];
      a = sum[7:0];
      p = p + ((w.opcode inside {8'h6D, 8'h7D, 8'h79}) ? 16'h0003 : 16'h0002);
    end else if (w.opcode inside {8'h2D, 8'h3D, 8'h39, 8'h29, 8'h25, 8'h21,
                                  8'h35, 8'h32, 8'h31}) begin
      a = a & w.operand;
      p = p + ((w.opcode inside {8'h2D, 8'h3D, 8'h39}) ? 16'h0003 : 16'h0002);
    end else if (w.opcode inside {8'h0F, 8'h1F, 8'h2F, 8'h3F,
                                  8'h4F, 8'h5F, 8'h6F, 8'h7F}) begin
      br = ~w.operand[w.opcode[6:4]];
      p = p + 16'h0003 + (br ? {{8{w.relOffset[7]}}, w.relOffset} : 16'h0000);
    end else begin
      ill = 1'b1;
      p = p + 16'h0001;
    end
    if (!br && !ill && w.opcode[3:0] != 4'hF) begin
      s[7] = a[7];
      s[1] = (a == 8'h00);
    end
    return {a, s, p, br, ill};
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    if (num_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic put(input logic [7:0] o, input logic [7:0] m, input logic [7:0] r);
    cods_prog_mem_inst.push({o, m, r});
  endtask

  // Runs until the memory is empty; clkEn drops at random, and for a long stretch if asked.
  task automatic drain(input bit freeze);
    for (int c = 0; c < 3000 && (cods_prog_mem_inst.q.size() != 0 || c < 60); c++) begin
      @(posedge mclk);
      seed = xs(seed);
      clkEn <= (freeze && c >= 20 && c < 60) ? 1'b0 : (seed[3:0] != 4'h0);
    end
  endtask

  // Reference state follows every instruction the core accepts; it freezes with clkEn.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      {expAcc, expStat, expPc, expBr, expIll} = {`CODS_ACC_RESET, `CODS_STAT_RESET, 18'h00000};
      expDone = 1'b0;
    end else if (clkEn) begin
      expDone = insnValid;
      {expBr, expIll} = 2'b00;
      if (insnValid) begin
        {expAcc, expStat, expPc, expBr, expIll} = predict(expAcc, expStat, expPc, insnIn);
      end
    end
  end

  // Outputs are compared mid-cycle, every cycle, reset included.
  always @(negedge mclk) begin
    check({8'h00, acc}, {8'h00, expAcc});
    check({8'h00, status}, {8'h00, expStat});
    check(pc, expPc);
    check({13'h0000, done, branchTaken, illegal}, {13'h0000, expDone, expBr, expIll});
  end

  // A hang is cut short well beyond the expected run length.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 8000) begin
      num_errors++;
      summarize();
    end
  end

  // Corner cases first: carry into zero, signed overflow, each bit test set and clear.
  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    put(8'h69, 8'hFF, 8'h00);
    put(8'h69, 8'h01, 8'h00);
    put(8'h69, 8'h7F, 8'h00);
    for (int b = 0; b < 8; b++) begin
      put({1'b0, b[2:0], 4'hF}, 8'h01 << b, 8'h7F);
      put({1'b0, b[2:0], 4'hF}, ~(8'h01 << b), 8'h80);
    end
    for (int i = 0; i < 426; i++) begin
      seed = xs(seed);
      put((i < 26) ? OPS[i] : (seed[31] ? OPS[seed[30:24] % 26] : seed[7:0]), seed[15:8],
        seed[23:16]);
    end
    drain(1'b1);
    for (int i = 0; i < 12; i++) begin
      put(OPS[i * 2], 8'hA5, 8'h10);
    end
    repeat (4) @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    drain(1'b0);
    clkEn <= 1'b1;
    repeat (5) @(posedge mclk);
    summarize();
  end
endmodule

`default_nettype wire
